//--- rtl/rst_seq.v
// Reset source collector and start-up sequencer.
// Assumes all inputs synchronous to CLK; config bits stand for config words.
// Operation
// RL1 - Low-power brown-out holds reset and clears the shared brown-out flag.
// RL2 - Low-power detector suits brown-out field 00 or 10; user's choice.
// RL3 - Config bit enables low-power detector; erased value leaves it off.
// RL4 - Pin reset disabled only when pin enable and low-voltage bits are 0.
// RL5 - Pin held low keeps reset; weak pull-up always on.
// RL6 - Short pulses on the reset pin are filtered and ignored.
// RL7 - Internal reset never drives the reset pin; input only.
// RL8 - Pin disabled: general input, pull-up under software control.
// RL9 - Watchdog time-out resets and records time-out and power-down flags.
// RL10 - Reset instruction resets and clears the software reset flag.
// RL11 - With stack reset enabled, overflow or underflow resets and flags.
// RL12 - Leaving programming mode runs the power-on sequence.
// RL13 - Power-up timer optionally delays start after power-on or brown-out.
// RL14 - Start only after timer expiry and pin release, when enabled.
// RL15 - Timer ignores pin; after pin rises, start 10 cycles later.
// RL16 - Internal reset held while any source active; flags kept.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_regs.vh"

module rst_seq #(
    parameter PWRT_CYCLES = `PWRT_CYCLES
) (
    input wire CLK,
    input wire SYS_RST,
    input wire [3:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    output reg IRQ,
    input wire POR_EVT,
    input wire SUPPLY_LOW,
    input wire RESET_PIN_IN,
    output reg RESET_PIN_OE_N,
    output reg RESET_PIN_OUT,
    output reg PULLUP_EN,
    output reg GPIO_IN,
    input wire WATCHDOG_TIMEOUT,
    input wire RESET_INSTR,
    input wire STACK_OVF,
    input wire STACK_UNF,
    input wire PROG_EXIT,
    output reg CORE_RST,
    output reg RUN
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam ST_HOLD = 2'b00;
    localparam ST_PWRT = 2'b01;
    localparam ST_DELAY = 2'b10;
    localparam ST_RUN = 2'b11;

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    wire pin_level;
    wire glitch;
    wire [7:0] rdata;
    wire [7:0] cause;
    wire [7:0] cfg;
    wire irq;
    reg [7:0] cause_clr;
    reg [7:0] irq_set;
    wire [7:0] pin_stat;

    rst_pin_filter u_filt (
        .clk(CLK),
        .rst(SYS_RST),
        .pin_in(RESET_PIN_IN),
        .pin_level_r(pin_level),
        .glitch_r(glitch)
    );

    assign pin_stat = {6'h00, glitch, pin_level};

    rst_regs u_regs (
        .clk(CLK),
        .rst(SYS_RST),
        .addr(ADDR),
        .wdata(WDATA),
        .wr(WR),
        .rd(RD),
        .cause_clr(cause_clr),
        .irq_set(irq_set),
        .pin_stat(pin_stat),
        .rdata_r(rdata),
        .cause_r(cause),
        .cfg_r(cfg),
        .irq_r(irq)
    );

    // ------------------------------------------------------------
    // Source collection
    // ------------------------------------------------------------
    wire pin_rst_en = cfg[`CFG_PIN_RST_EN] | cfg[`CFG_LOW_VOLT_PROG];  // RL4
    wire lp_det_hit = cfg[`CFG_LP_DET_EN] & SUPPLY_LOW;  // RL3
    wire stack_en = cfg[`CFG_STACK_RST];
    wire pin_hold = pin_rst_en & ~pin_level;  // RL5
    wire ovf_hit = stack_en & STACK_OVF;  // RL11
    wire unf_hit = stack_en & STACK_UNF;  // RL11
    // Power-class events restart the power-up timer
    wire pwr_evt = POR_EVT | lp_det_hit | PROG_EXIT;  // RL12
    wire soft_evt = WATCHDOG_TIMEOUT | RESET_INSTR | ovf_hit | unf_hit;
    wire any_src = pwr_evt | soft_evt | pin_hold;  // RL16

    always @* begin
        cause_clr = 8'h00;
        cause_clr[`CAUSE_BROWNOUT] = lp_det_hit;  // RL1
        cause_clr[`CAUSE_SOFT] = RESET_INSTR;  // RL10
        cause_clr[`CAUSE_TIMEOUT] = WATCHDOG_TIMEOUT;  // RL9
        cause_clr[`CAUSE_PWRDN] = WATCHDOG_TIMEOUT;  // RL9
        cause_clr[`CAUSE_OVF] = ovf_hit;
        cause_clr[`CAUSE_UNF] = unf_hit;
        irq_set = cause_clr;
        irq_set[6] = glitch;
    end

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [15:0] pwrt_cnt_r;
    reg pwrt_done_r;
    reg [3:0] dly_r;
    reg pwrt_arm_r;

    // Timer runs whatever the pin does
    always @(posedge CLK) begin
        if (SYS_RST) begin
            pwrt_cnt_r <= 16'h0000;
            pwrt_done_r <= 1'b0;
            pwrt_arm_r <= 1'b1;
        end else if (pwr_evt) begin
            pwrt_cnt_r <= 16'h0000;
            pwrt_done_r <= 1'b0;
            pwrt_arm_r <= 1'b1;
        end else if (!pwrt_arm_r || !cfg[`CFG_PWRT_EN]) begin
            pwrt_done_r <= 1'b1;  // RL13
        end else if (pwrt_cnt_r == PWRT_CYCLES[15:0] - 16'h0001) begin
            pwrt_done_r <= 1'b1;  // RL15
            pwrt_arm_r <= 1'b0;
        end else begin
            pwrt_cnt_r <= pwrt_cnt_r + 16'h0001;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_HOLD: begin
                if (!pwr_evt && !soft_evt) begin
                    state_nxt = ST_PWRT;
                end
            end
            ST_PWRT: begin
                if (pwrt_done_r && !pin_hold) begin
                    state_nxt = ST_DELAY;  // RL14
                end
            end
            ST_DELAY: begin
                if (dly_r == `START_DELAY - 4'h1) begin
                    state_nxt = ST_RUN;  // RL15
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
        if (any_src) begin
            state_nxt = ST_HOLD;  // RL16
        end else if (pin_hold) begin
            state_nxt = ST_PWRT;
        end
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= ST_HOLD;
            dly_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_DELAY) begin
                dly_r <= dly_r + 4'h1;
            end else begin
                dly_r <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    // Read data comes straight from the slave's flop so it stands one cycle after the strobe
    always @* begin
        RDATA = rdata;
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
            RESET_PIN_OE_N <= 1'b1;
            RESET_PIN_OUT <= 1'b0;
            PULLUP_EN <= 1'b1;
            GPIO_IN <= 1'b1;
            CORE_RST <= 1'b1;
            RUN <= 1'b0;
        end else begin
            IRQ <= irq;
            RESET_PIN_OE_N <= 1'b1;  // RL7
            RESET_PIN_OUT <= 1'b0;  // RL7
            PULLUP_EN <= pin_rst_en | cfg[`CFG_WPU_SW];  // RL8
            GPIO_IN <= pin_rst_en ? 1'b1 : RESET_PIN_IN;  // RL8
            CORE_RST <= (state_nxt != ST_RUN);
            RUN <= (state_nxt == ST_RUN);
        end
    end
endmodule // rst_seq

`default_nettype wire

//--- inc/rst_seq_regs.vh
// Constants for the reset source collector and start-up sequencer.
// Included by the register slave, the pin filter and the sequencer; definitions only.
`ifndef RST_SEQ_REGS_VH
`define RST_SEQ_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CAUSE 4'h0
`define OFS_IRQ_STAT 4'h1
`define OFS_IRQ_MASK 4'h2
`define OFS_CONFIG 4'h3
`define OFS_PIN 4'h4

// ----------------------------------------------------------------
// Cause flag fields (bits 0-3 cleared by events, stack bits set)
// ----------------------------------------------------------------
`define CAUSE_BROWNOUT 0
`define CAUSE_SOFT 1
`define CAUSE_TIMEOUT 2
`define CAUSE_PWRDN 3
`define CAUSE_OVF 4
`define CAUSE_UNF 5
`define CAUSE_RST 8'h0f
`define CAUSE_SET_MASK 8'h30

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define CFG_LP_DET_EN 0
`define CFG_PIN_RST_EN 1
`define CFG_LOW_VOLT_PROG 2
`define CFG_STACK_RST 3
`define CFG_PWRT_EN 4
`define CFG_WPU_SW 5
`define CFG_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 50
`define PWRT_US 64
`define PWRT_CYCLES (`PWRT_US * `CLK_MHZ)
`define START_DELAY 4'ha
`define FILT_LEN 4'h4

`endif

//--- rtl/rst_pin_filter.v
// Glitch filter on the external reset pin.
// Assumes the pin level is already synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_regs.vh"

module rst_pin_filter (
    input wire clk,
    input wire rst,
    input wire pin_in,
    output reg pin_level_r,
    output reg glitch_r
);
    reg [3:0] cnt_r;

    // Level changes only after FILT_LEN stable samples; short pulses are flagged
    always @(posedge clk) begin
        if (rst) begin
            cnt_r <= 4'h0;
            pin_level_r <= 1'b1;
            glitch_r <= 1'b0;
        end else begin
            glitch_r <= 1'b0;
            if (pin_in == pin_level_r) begin
                if (cnt_r != 4'h0) begin
                    glitch_r <= 1'b1;  // RL6
                end
                cnt_r <= 4'h0;
            end else if (cnt_r == `FILT_LEN - 4'h1) begin
                pin_level_r <= pin_in;
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule // rst_pin_filter

`default_nettype wire

//--- rtl/rst_regs.v
// Register slave: cause flags, config, interrupt status and mask.
// Assumes one-cycle strobes, never both at once; read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_regs.vh"

module rst_regs (
    input wire clk,
    input wire rst,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] cause_clr,
    input wire [7:0] irq_set,
    input wire [7:0] pin_stat,
    output reg [7:0] rdata_r,
    output reg [7:0] cause_r,
    output reg [7:0] cfg_r,
    output reg irq_r
);
    reg [7:0] stat_r;
    reg [7:0] mask_r;
    reg [7:0] stat_nxt;

    always @* begin
        stat_nxt = stat_r;
        if (wr && addr == `OFS_IRQ_STAT) begin
            stat_nxt = stat_r & ~wdata;
        end
        // Set wins over a clear in the same cycle
        stat_nxt = stat_nxt | irq_set;
    end

    always @(posedge clk) begin
        if (rst) begin
            cause_r <= `CAUSE_RST;
            cfg_r <= `CFG_RST;
            stat_r <= 8'h00;
            mask_r <= 8'h00;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= |(stat_nxt & mask_r);
            // Events clear the low flags and set the stack flags; event wins over software
            if (wr && addr == `OFS_CAUSE) begin
                cause_r <= (wdata & ~(cause_clr & ~`CAUSE_SET_MASK)) | (cause_clr & `CAUSE_SET_MASK);  // RL16
            end else begin
                cause_r <= (cause_r & ~(cause_clr & ~`CAUSE_SET_MASK)) | (cause_clr & `CAUSE_SET_MASK);  // RL11
            end
            if (wr && addr == `OFS_CONFIG) begin
                cfg_r <= wdata;
            end
            if (wr && addr == `OFS_IRQ_MASK) begin
                mask_r <= wdata;
            end
            rdata_r <= 8'h00;
            if (rd) begin
                if (addr == `OFS_CAUSE) begin
                    rdata_r <= cause_r;
                end else if (addr == `OFS_IRQ_STAT) begin
                    rdata_r <= stat_r;
                end else if (addr == `OFS_IRQ_MASK) begin
                    rdata_r <= mask_r;
                end else if (addr == `OFS_CONFIG) begin
                    rdata_r <= cfg_r;
                end else if (addr == `OFS_PIN) begin
                    rdata_r <= pin_stat;
                end
            end
        end
    end
endmodule // rst_regs

`default_nettype wire

//--- tb/rst_seq_monitor.sv
// Port checker for the reset sequencer.
// Assumes bind to rst_seq; config is shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
module rst_seq_chk #(
    parameter PWRT_CYCLES = 20
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ,
    input wire logic SUPPLY_LOW,
    input wire logic RESET_PIN_IN,
    input wire logic RESET_PIN_OE_N,
    input wire logic RESET_PIN_OUT,
    input wire logic PULLUP_EN,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic RESET_INSTR,
    input wire logic STACK_OVF,
    input wire logic STACK_UNF,
    input wire logic CORE_RST,
    input wire logic RUN
);
    logic [7:0] cfg_r;
    logic [4:0] hold_r;
    wire pin_en = cfg_r[1] | cfg_r[2];
    // System reset counts as a long hold, so the first start never trips
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_r <= 8'h00;
            hold_r <= 5'h1f;
        end else begin
            if (WR && ADDR == 4'h3) cfg_r <= WDATA;
            hold_r <= !CORE_RST ? 5'h00 : (hold_r == 5'h1f ? hold_r : hold_r + 5'h01);
        end
    end
    // ----
    // Checks
    // ----
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_pin_input_only: assert property (RESET_PIN_OE_N && !RESET_PIN_OUT)
        else $error("reset pin driven");
    a_instr_resets: assert property (RESET_INSTR |=> CORE_RST)
        else $error("no reset after instruction");
    a_watchdog_resets: assert property (WATCHDOG_TIMEOUT |=> CORE_RST)
        else $error("no reset after watchdog");
    a_low_supply_holds: assert property (SUPPLY_LOW && cfg_r[0] |=> CORE_RST)
        else $error("no reset on low supply");
    a_stack_resets: assert property ((STACK_OVF || STACK_UNF) && cfg_r[3] |=> CORE_RST)
        else $error("no reset on stack fault");
    a_pin_holds: assert property ((pin_en && !RESET_PIN_IN) [*8] |=> CORE_RST && !RUN)
        else $error("pin low without reset");
    a_start_delay: assert property ($rose(RUN) |-> hold_r >= 5'd10)
        else $error("start too soon");
    a_run_exclusive: assert property (RUN != CORE_RST)
        else $error("run during reset");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside slot");
    a_pullup_rule: assert property ($stable(cfg_r) [*3] |-> PULLUP_EN == (pin_en | cfg_r[5]))
        else $error("pull-up wrong");
    c_instr: cover property (RESET_INSTR ##1 CORE_RST);
    c_run: cover property ($rose(RUN));
    c_irq: cover property ($rose(IRQ));
endmodule // rst_seq_chk
bind rst_seq rst_seq_chk #(.PWRT_CYCLES(PWRT_CYCLES)) chk (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .IRQ, .SUPPLY_LOW, .RESET_PIN_IN, .RESET_PIN_OE_N, .RESET_PIN_OUT, .PULLUP_EN, .WATCHDOG_TIMEOUT,
    .RESET_INSTR, .STACK_OVF, .STACK_UNF, .CORE_RST, .RUN);
`default_nettype wire

//--- tb/rst_pin_supply_model.sv
// Reset pin driver and supply monitor beside the sequencer.
// Assumes the bench commands pin holds and supply dips.
`timescale 1ns/1ps
`default_nettype none
module rst_pin_supply_model #(
    parameter logic [1:0] BROWNOUT_ENABLE_FIELD = 2'b00
) (
    input wire logic CLK,
    input wire logic hold_low,
    input wire logic dip,
    input wire logic PULLUP_EN,
    input wire logic RESET_PIN_OE_N,
    input wire logic RESET_PIN_OUT,
    output logic RESET_PIN_IN,
    output logic SUPPLY_LOW
);
    logic float_r = 1'b0;
    // ----
    // Pin and supply
    // ----
    // An unpulled, undriven pin wanders so a missing pull-up cannot pass by luck
    always @(posedge CLK) float_r <= !float_r;
    assign RESET_PIN_IN = !RESET_PIN_OE_N ? RESET_PIN_OUT : hold_low ? 1'b0 : PULLUP_EN ? 1'b1 : float_r;
    assign SUPPLY_LOW = dip && (BROWNOUT_ENABLE_FIELD == 2'b00 || BROWNOUT_ENABLE_FIELD == 2'b10);
endmodule // rst_pin_supply_model
`default_nettype wire

//--- tb/rst_seq_bench.sv
// Self-checking bench for the reset sequencer.
// Assumes the partner model drives the pin and supply lines.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("Error at %0t got %h exp %h", $time, g, e); end end
module rst_seq_bench;
    localparam int PW = 20;
    logic clk, sys_rst, wr, rd, hold_low, irq, pin, oe_n, pout, pu, gpio, core_rst, run, lp;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [6:0] ev;
    int err_total, compares, n;
    rst_seq #(.PWRT_CYCLES(PW)) uut (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ(irq), .POR_EVT(ev[0]), .SUPPLY_LOW(lp), .RESET_PIN_IN(pin), .RESET_PIN_OE_N(oe_n),
        .RESET_PIN_OUT(pout), .PULLUP_EN(pu), .GPIO_IN(gpio), .WATCHDOG_TIMEOUT(ev[1]), .RESET_INSTR(ev[2]),
        .STACK_OVF(ev[3]), .STACK_UNF(ev[4]), .PROG_EXIT(ev[5]), .CORE_RST(core_rst), .RUN(run));
    rst_pin_supply_model model (.CLK(clk), .hold_low(hold_low), .dip(ev[6]), .PULLUP_EN(pu),
        .RESET_PIN_OE_N(oe_n), .RESET_PIN_OUT(pout), .RESET_PIN_IN(pin), .SUPPLY_LOW(lp));
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    // ----
    // Bus and event tasks
    // ----
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata & m, e)
    endtask
    task automatic fire(input int i, input logic e);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(negedge clk);
        `CHK(core_rst, e)
    endtask
    task automatic wait_run(input int lo, input int hi);
        n = 0;
        while (run !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask
    task automatic hold(input int c);
        @(posedge clk);
        hold_low <= 1'b1;
        repeat (c) @(posedge clk);
        hold_low <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("Compares %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        wait_run(0, 16);
        rd_chk(4'h0, 8'hff, 8'h0f);
        rd_chk(4'h3, 8'hff, 8'h00);
        wr_reg(4'hf, 8'hff);
        rd_chk(4'hf, 8'hff, 8'h00);
        `CHK({oe_n, pout}, 2'b10)
    endtask
    task automatic t_sources;
        fire(6, 1'b0);
        fire(3, 1'b0);
        wr_reg(4'h3, 8'h09);
        fire(6, 1'b1);
        wait_run(10, 16);
        rd_chk(4'h0, 8'h01, 8'h00);
        fire(1, 1'b1);
        wait_run(10, 16);
        rd_chk(4'h0, 8'h04, 8'h00);
        fire(3, 1'b1);
        wait_run(10, 16);
        fire(4, 1'b1);
        wait_run(10, 16);
        rd_chk(4'h1, 8'h30, 8'h30);
        rd_chk(4'h0, 8'h30, 8'h30);
    endtask
    task automatic t_instr_irq;
        wr_reg(4'h2, 8'h02);
        fire(2, 1'b1);
        wait_run(10, 16);
        rd_chk(4'h0, 8'h02, 8'h00);
        `CHK(irq, 1'b1)
        wr_reg(4'h1, 8'h02);
        rd_chk(4'h1, 8'h02, 8'h00);
        `CHK(irq, 1'b0)
        wr_reg(4'h2, 8'h00);
        fire(2, 1'b1);
        wait_run(10, 16);
        `CHK(irq, 1'b0)
        wr_reg(4'h0, 8'h02);
        rd_chk(4'h0, 8'h02, 8'h02);
    endtask
    task automatic t_pin;
        wr_reg(4'h3, 8'h12);
        hold(2);
        `CHK(core_rst, 1'b0)
        rd_chk(4'h1, 8'h40, 8'h40);
        @(posedge clk);
        hold_low <= 1'b1;
        fire(0, 1'b1);
        repeat (PW + 20) @(posedge clk);
        `CHK(run, 1'b0)
        hold_low <= 1'b0;
        wait_run(10, 18);
        fire(5, 1'b1);
        wait_run(PW + 10, PW + 20);
        wr_reg(4'h3, 8'h04);
        @(posedge clk);
        hold_low <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK({core_rst, pu}, 2'b11)
        hold_low <= 1'b0;
        wait_run(10, 18);
        wr_reg(4'h3, 8'h20);
        hold(10);
        `CHK({core_rst, pu}, 2'b01)
        @(posedge clk);
        hold_low <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(gpio, 1'b0)
        hold_low <= 1'b0;
        wr_reg(4'h3, 8'h00);
        repeat (3) @(posedge clk);
        `CHK(pu, 1'b0)
    endtask
    initial begin
        sys_rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        ev = 7'h00;
        hold_low = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_sources;
        t_instr_irq;
        t_pin;
        tally_and_finish;
    end
    initial begin
        #200000;
        err_total++;
        tally_and_finish;
    end
endmodule // rst_seq_bench
`default_nettype wire
